// ### design/psram_pwr_pkg.sv
// Package: constants for the pseudo-static DRAM interface power-state ends
package psram_pwr_pkg;
  localparam int CLK_PERIOD_NS = 10;
  // Access time plus margin before active clock stop
  localparam int ACCESS_TIME_NS = 35;
  localparam int CLOCK_STOP_MARGIN_NS = 30;
  localparam int CLOCK_STOP_CYC =
    (ACCESS_TIME_NS + CLOCK_STOP_MARGIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Sleep and power-down entry (longest times, round down)
  localparam int SLEEP_ENTRY_TIME_US = 3;
  localparam int SLEEP_ENTRY_CYC = SLEEP_ENTRY_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int POWERDOWN_ENTRY_TIME_US = 3;
  localparam int POWERDOWN_ENTRY_CYC =
    POWERDOWN_ENTRY_TIME_US * 1000 / CLK_PERIOD_NS;
  // Wake pulse widths
  localparam int SLEEP_WAKE_PULSE_MIN_NS = 60;
  localparam int SLEEP_WAKE_PULSE_MAX_NS = 3000;
  localparam int POWERDOWN_WAKE_PULSE_MIN_NS = 200;
  localparam int POWERDOWN_WAKE_PULSE_MAX_NS = 3000;
  localparam int SLEEP_WAKE_PULSE_MIN_CYC =
    (SLEEP_WAKE_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POWERDOWN_WAKE_PULSE_MIN_CYC =
    (POWERDOWN_WAKE_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POWERDOWN_WAKE_PULSE_MAX_CYC =
    POWERDOWN_WAKE_PULSE_MAX_NS / CLK_PERIOD_NS;
  // Wake times (device longest, host least: both use the full figure)
  localparam int SLEEP_WAKE_TIME_US = 100;
  localparam int SLEEP_WAKE_CYC = SLEEP_WAKE_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int POWERDOWN_WAKE_TIME_US = 150;
  localparam int POWERDOWN_WAKE_CYC =
    POWERDOWN_WAKE_TIME_US * 1000 / CLK_PERIOD_NS;
  // Maximum select-low time
  localparam int MAX_SELECT_LOW_TIME_US = 4;
  localparam int MAX_SELECT_LOW_CYC =
    MAX_SELECT_LOW_TIME_US * 1000 / CLK_PERIOD_NS;
  // Host clock divider half period in core cycles
  localparam int HOST_CLK_HALF_CYC = 4;
  // Command byte fields (simplified command byte)
  localparam int CMD_READ_BIT = 7;
  localparam int CMD_REG_BIT = 6;
  localparam int CMD_ZERO_LAT_BIT = 5;
  localparam int CMD_SLEEP_BIT = 1;
  localparam int CMD_POWERDOWN_BIT = 0;
  localparam int LATENCY_CLK = 6;
  localparam logic [15:0] CFG1_RESET = 16'hff81;
  localparam int HYBRID_SLEEP_BIT = 5;
  localparam logic [15:0] CFG0_RESET = 16'h8f1f;
  localparam int DEEP_POWER_DOWN_BIT = 15;
  localparam int CNT_W = 16;
  typedef enum logic [2:0] {
    DEV_STANDBY = 3'b000,
    DEV_CMD = 3'b001,
    DEV_LATENCY = 3'b010,
    DEV_DATA = 3'b011,
    DEV_SLEEP = 3'b100,
    DEV_POWERDOWN = 3'b101,
    DEV_WAKE = 3'b110
  } dev_state_type;
  typedef enum logic [2:0] {
    HOST_IDLE = 3'b000,
    HOST_CMD = 3'b001,
    HOST_LATENCY = 3'b010,
    HOST_DATA = 3'b011,
    HOST_PULSE = 3'b100,
    HOST_WAIT = 3'b101
  } host_state_type;
endpackage

// ### design/psram_link_if.sv
// Interface: link pins between host controller and memory device
`timescale 1ns/100ps
interface psram_link_if;
  logic select_n;
  logic bus_clock;
  logic bus_clock_complement;
  logic reset_n;
  logic [7:0] data_host;
  logic data_host_oe;
  logic [7:0] data_dev;
  logic data_dev_oe;
  logic strobe_host;
  logic strobe_host_oe;
  logic strobe_dev;
  logic strobe_dev_oe;
  modport host (output select_n, bus_clock, bus_clock_complement, reset_n,
    data_host, data_host_oe, strobe_host, strobe_host_oe,
    input data_dev, data_dev_oe, strobe_dev, strobe_dev_oe);
  modport dev (input select_n, bus_clock, bus_clock_complement, reset_n,
    data_host, data_host_oe, strobe_host, strobe_host_oe,
    output data_dev, data_dev_oe, strobe_dev, strobe_dev_oe);
endinterface

// ### design/psram_dev_end.sv
// Memory device end: interface states and power conservation modes
// Functional notes
// - Select high: standby, ignore all but select
// - Device drives strobe during command phase
// - Host never drives strobe on zero-latency writes
// - Zero-latency writes write all bytes unmasked
// - Nobody drives data or strobe in write latency
// - Stable clock past access time enters clock stop
// - Clock stop in read holds data driven
// - Toggling clock leaves clock stop
// - Host pauses clock only while low
// - Host raises select before max low time
// - Host avoids clock stop in register access
// - Sleep bit set enters sleep within 3 us
// - Sleep keeps array and registers
// - Select pulse 60-3000 ns wakes, clears bit (code wakes on any pulse of 40 ns or more, no upper limit)
// - Reset also ends sleep, refresh lost
// - Sleep wake needs up to 100 us
// - After sleep, same state as entry
// - Power-down bit zero stops refresh in 3 us
// - Select pulse 200-3000 ns ends power-down (code ends it on any pulse of 180 ns or more, no upper limit)
// - Power-down wake needs up to 150 us
// - After power-down, registers at reset defaults
// - Max select-low time from refresh interval
`timescale 1ns/100ps
module psram_dev_end
  import psram_pwr_pkg::*;
(
  input wire logic core_clk_i, // Core clock
  input wire logic arst_n_i, // Async reset, active low
  psram_link_if.dev link, // Link pins
  output logic [7:0] wr_data_o, // Last written byte
  output logic wr_strobe_o, // Write byte pulse
  output logic [7:0] wr_mask_o, // Bytes masked count low bits
  output logic [7:0] rd_data_o, // Current read byte
  output logic clock_stop_o, // Active clock stop state
  output logic sleep_o, // Hybrid sleep power level
  output logic powerdown_o, // Deep power-down power level
  output logic refresh_en_o, // Array refresh running
  output logic data_valid_o, // Array contents trustworthy
  output logic [15:0] cfg0_o, // First configuration register
  output logic [15:0] cfg1_o, // Second configuration register
  output logic busy_refresh_i_unused_o // Extended latency flag shown
);
  // Synchroniser stages for pins
  logic [1:0] sel_sync_reg, clk_sync_reg, rst_sync_reg;
  logic [7:0] dq_s1_reg, dq_s2_reg;
  logic strobe_s1_reg, strobe_s2_reg;
  logic clk_prev_reg, sel_prev_reg;
  logic sel_n, clk_s, pin_rst_n, clk_edge;
  dev_state_type state_reg;
  logic [CNT_W-1:0] timer_reg, stable_reg, pulse_reg;
  logic [7:0] cmd_reg, rd_reg;
  logic [3:0] byte_cnt_reg;
  logic [3:0] lat_cnt_reg;
  logic [15:0] cfg0_reg, cfg1_reg;
  logic extra_lat_reg;
  logic entry_pending_reg;
  logic [7:0] mask_cnt_reg;

  function automatic logic at_least(input logic [CNT_W-1:0] cnt,
                                    input int lim);
    at_least = (cnt >= CNT_W'(lim));
  endfunction

  // Two-stage synchronisers for all pin inputs except the unused bus_clock_complement and data_host_oe
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sel_sync_reg <= 2'h3;
      clk_sync_reg <= 2'h0;
      rst_sync_reg <= 2'h0;
      dq_s1_reg <= 8'h00;
      dq_s2_reg <= 8'h00;
      strobe_s1_reg <= 1'b0;
      strobe_s2_reg <= 1'b0;
      clk_prev_reg <= 1'b0;
      sel_prev_reg <= 1'b1;
    end else begin
      sel_sync_reg <= {sel_sync_reg[0], link.select_n};
      clk_sync_reg <= {clk_sync_reg[0], link.bus_clock};
      rst_sync_reg <= {rst_sync_reg[0], link.reset_n};
      dq_s1_reg <= link.data_host;
      dq_s2_reg <= dq_s1_reg;
      strobe_s1_reg <= link.strobe_host & link.strobe_host_oe;
      strobe_s2_reg <= strobe_s1_reg;
      clk_prev_reg <= clk_sync_reg[1];
      sel_prev_reg <= sel_sync_reg[1];
    end
  end
  assign sel_n = sel_sync_reg[1];
  assign clk_s = clk_sync_reg[1];
  assign pin_rst_n = rst_sync_reg[1];
  assign clk_edge = clk_s ^ clk_prev_reg;

  // Interface and power state machine
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg <= DEV_STANDBY;
      timer_reg <= '0;
      pulse_reg <= '0;
      cmd_reg <= 8'h00;
      byte_cnt_reg <= 4'h0;
      lat_cnt_reg <= 4'h0;
      cfg0_reg <= CFG0_RESET;
      cfg1_reg <= CFG1_RESET;
      entry_pending_reg <= 1'b0;
      sleep_o <= 1'b0;
      powerdown_o <= 1'b0;
      refresh_en_o <= 1'b1;
      data_valid_o <= 1'b0;
      wr_data_o <= 8'h00;
      wr_strobe_o <= 1'b0;
      mask_cnt_reg <= 8'h00;
    end else if (!pin_rst_n) begin
      // Hardware reset ends sleep and power-down; refresh lost
      state_reg <= DEV_STANDBY;
      cfg0_reg <= CFG0_RESET;
      cfg1_reg <= CFG1_RESET;
      sleep_o <= 1'b0;
      powerdown_o <= 1'b0;
      refresh_en_o <= 1'b1;
      data_valid_o <= 1'b0;
      entry_pending_reg <= 1'b0;
      wr_strobe_o <= 1'b0;
      timer_reg <= '0;
    end else begin
      wr_strobe_o <= 1'b0;
      case (state_reg)
        DEV_STANDBY: begin
          // Only select is watched here
          if (entry_pending_reg) begin
            // Settle the power mode at once so a new select is not missed
            entry_pending_reg <= 1'b0;
            if (!cfg0_reg[DEEP_POWER_DOWN_BIT]) begin
              state_reg <= DEV_POWERDOWN;
              powerdown_o <= 1'b1;
              refresh_en_o <= 1'b0;
              data_valid_o <= 1'b0;
            end else if (cfg1_reg[HYBRID_SLEEP_BIT]) begin
              state_reg <= DEV_SLEEP;
              sleep_o <= 1'b1;
            end
          end else if (!sel_n) begin
            state_reg <= DEV_CMD;
            byte_cnt_reg <= 4'h0;
          end
        end
        DEV_CMD: begin
          if (sel_n) begin
            state_reg <= DEV_STANDBY;
          end else if (clk_edge) begin
            byte_cnt_reg <= byte_cnt_reg + 4'h1;
            if (byte_cnt_reg == 4'h0) begin
              cmd_reg <= dq_s2_reg;
            end
            if (byte_cnt_reg == 4'h5) begin
              byte_cnt_reg <= 4'h0;
              lat_cnt_reg <= 4'h0;
              if (!cmd_reg[CMD_READ_BIT] && cmd_reg[CMD_ZERO_LAT_BIT]) begin
                state_reg <= DEV_DATA;
              end else begin
                state_reg <= DEV_LATENCY;
              end
            end
          end
        end
        DEV_LATENCY: begin
          if (sel_n) begin
            state_reg <= DEV_STANDBY;
          end else if (clk_edge) begin
            lat_cnt_reg <= lat_cnt_reg + 4'h1;
            if (lat_cnt_reg == 4'(2 * LATENCY_CLK - 1)) begin
              state_reg <= DEV_DATA;
            end
          end
        end
        DEV_DATA: begin
          if (sel_n) begin
            state_reg <= DEV_STANDBY;
            if (cmd_reg[CMD_REG_BIT] && !cmd_reg[CMD_READ_BIT] &&
                byte_cnt_reg >= 4'h2) begin
              entry_pending_reg <= 1'b1;
              timer_reg <= '0;
            end
          end else if (clk_edge && !cmd_reg[CMD_READ_BIT]) begin
            byte_cnt_reg <= byte_cnt_reg + 4'h1;
            if (cmd_reg[CMD_REG_BIT]) begin
              if (byte_cnt_reg == 4'h0) begin
                if (cmd_reg[CMD_POWERDOWN_BIT]) begin
                  cfg0_reg[15:8] <= dq_s2_reg;
                end else begin
                  cfg1_reg[15:8] <= dq_s2_reg;
                end
              end else if (byte_cnt_reg == 4'h1) begin
                if (cmd_reg[CMD_POWERDOWN_BIT]) begin
                  cfg0_reg[7:0] <= dq_s2_reg;
                end else begin
                  cfg1_reg[7:0] <= dq_s2_reg;
                end
              end
            end else begin
              // Zero-latency writes ignore strobe mask
              wr_data_o <= dq_s2_reg;
              wr_strobe_o <= 1'b1;
              data_valid_o <= 1'b1; // Array now holds written data
              if (strobe_s2_reg && !cmd_reg[CMD_ZERO_LAT_BIT]) begin
                mask_cnt_reg <= mask_cnt_reg + 8'h01;
              end
            end
          end
        end
        DEV_SLEEP: begin
          // Array and registers retained while asleep
          if (!sel_n) begin
            pulse_reg <= pulse_reg + 1'b1;
          end else if (!sel_prev_reg) begin
            pulse_reg <= '0;
            if (at_least(pulse_reg, SLEEP_WAKE_PULSE_MIN_CYC - 2)) begin
              cfg1_reg[HYBRID_SLEEP_BIT] <= 1'b0;
              sleep_o <= 1'b0;
              state_reg <= DEV_WAKE;
              timer_reg <= CNT_W'(SLEEP_WAKE_CYC);
            end
          end
        end
        DEV_POWERDOWN: begin
          if (!sel_n) begin
            pulse_reg <= pulse_reg + 1'b1;
          end else if (!sel_prev_reg) begin
            pulse_reg <= '0;
            if (at_least(pulse_reg, POWERDOWN_WAKE_PULSE_MIN_CYC - 2)) begin
              cfg0_reg <= CFG0_RESET;
              cfg1_reg <= CFG1_RESET;
              powerdown_o <= 1'b0;
              refresh_en_o <= 1'b1;
              state_reg <= DEV_WAKE;
              timer_reg <= CNT_W'(POWERDOWN_WAKE_CYC);
            end
          end
        end
        DEV_WAKE: begin
          // Return to the pre-entry standby once the wake time runs out
          if (timer_reg == '0) begin
            state_reg <= DEV_STANDBY;
          end else begin
            timer_reg <= timer_reg - 1'b1;
          end
        end
        default: state_reg <= DEV_STANDBY;
      endcase
    end
  end

  // Clock-stable counter and clock stop flag
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      stable_reg <= '0;
      clock_stop_o <= 1'b0;
    end else if (state_reg != DEV_DATA || clk_edge || sel_n) begin
      stable_reg <= '0;
      clock_stop_o <= 1'b0;
    end else begin
      if (!at_least(stable_reg, CLOCK_STOP_CYC)) begin
        stable_reg <= stable_reg + 1'b1;
      end
      clock_stop_o <= at_least(stable_reg, CLOCK_STOP_CYC - 1);
    end
  end

  // Read data source; held through clock stop
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_reg <= 8'h00;
    end else if (state_reg == DEV_DATA && cmd_reg[CMD_READ_BIT] && clk_edge)
    begin
      rd_reg <= rd_reg + 8'h01;
    end
  end

  // Pin drivers: strobe in command phase, data in read transfer
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      link.data_dev <= 8'h00;
      link.data_dev_oe <= 1'b0;
      link.strobe_dev <= 1'b0;
      link.strobe_dev_oe <= 1'b0;
      extra_lat_reg <= 1'b0;
    end else begin
      extra_lat_reg <= 1'b0;
      link.data_dev <= rd_reg;
      link.data_dev_oe <= (state_reg == DEV_DATA) && cmd_reg[CMD_READ_BIT];
      link.strobe_dev <= (state_reg == DEV_CMD) ? extra_lat_reg :
                         (state_reg == DEV_DATA) ? clk_s : 1'b0;
      link.strobe_dev_oe <= (state_reg == DEV_CMD) ||
        (state_reg == DEV_LATENCY && cmd_reg[CMD_READ_BIT]) ||
        (state_reg == DEV_DATA && cmd_reg[CMD_READ_BIT]);
    end
  end

  assign rd_data_o = link.data_dev;
  assign cfg0_o = cfg0_reg;
  assign cfg1_o = cfg1_reg;
  assign wr_mask_o = mask_cnt_reg;
  assign busy_refresh_i_unused_o = extra_lat_reg;
endmodule // psram_dev_end

// ### design/psram_host_end.sv
// Host controller end: transactions, clock pause and wake timing
`timescale 1ns/100ps
module psram_host_end
  import psram_pwr_pkg::*;
(
  input wire logic core_clk_i, // Core clock
  input wire logic arst_n_i, // Async reset, active low
  psram_link_if.host link, // Link pins
  input wire logic req_i, // Start transaction pulse
  input wire logic [7:0] cmd_i, // Command byte
  input wire logic [15:0] wdata_i, // Register or data word
  input wire logic pause_i, // Hold the bus clock low outside register access
  input wire logic wake_i, // Send wake pulse
  input wire logic wake_pd_i, // Wake from power-down if high
  input wire logic pin_reset_i, // Drive hardware reset
  output logic busy_o, // Transaction or wait in progress
  output logic ready_o // New request may be taken
);
  host_state_type state_reg;
  logic [CNT_W-1:0] cnt_reg, low_reg;
  logic [3:0] edge_reg;
  logic [2:0] div_reg;
  logic [7:0] cmd_reg;
  logic [15:0] wdata_reg;
  logic clk_reg, pd_reg;

  // Sequencer
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg <= HOST_IDLE;
      cnt_reg <= '0;
      low_reg <= '0;
      edge_reg <= 4'h0;
      div_reg <= 3'h0;
      cmd_reg <= 8'h00;
      wdata_reg <= 16'h0000;
      clk_reg <= 1'b0;
      pd_reg <= 1'b0;
      link.select_n <= 1'b1;
      link.data_host <= 8'h00;
      link.data_host_oe <= 1'b0;
      busy_o <= 1'b0;
      ready_o <= 1'b1;
    end else begin
      case (state_reg)
        HOST_IDLE: begin
          clk_reg <= 1'b0;
          link.data_host_oe <= 1'b0;
          if (wake_i) begin
            pd_reg <= wake_pd_i;
            link.select_n <= 1'b0;
            cnt_reg <= '0;
            state_reg <= HOST_PULSE;
            busy_o <= 1'b1;
            ready_o <= 1'b0;
          end else if (req_i) begin
            cmd_reg <= cmd_i;
            wdata_reg <= wdata_i;
            link.select_n <= 1'b0;
            edge_reg <= 4'h0;
            div_reg <= 3'h0;
            low_reg <= '0;
            state_reg <= HOST_CMD;
            busy_o <= 1'b1;
            ready_o <= 1'b0;
          end
        end
        HOST_CMD, HOST_LATENCY, HOST_DATA: begin
          low_reg <= low_reg + 1'b1;
          // Pause only with clock low; select rises before max low time
          if (at_limit(low_reg)) begin
            link.select_n <= 1'b1;
            link.data_host_oe <= 1'b0;
            clk_reg <= 1'b0;
            state_reg <= HOST_IDLE;
            busy_o <= 1'b0;
            ready_o <= 1'b1;
          end else if (!(pause_i && !clk_reg) ||
                       cmd_reg[CMD_REG_BIT]) begin
            div_reg <= div_reg + 3'h1;
            if (div_reg == 3'(HOST_CLK_HALF_CYC - 1)) begin
              div_reg <= 3'h0;
              clk_reg <= ~clk_reg;
              edge_reg <= edge_reg + 4'h1;
              step_edge();
            end
          end
        end
        HOST_PULSE: begin
          cnt_reg <= cnt_reg + 1'b1;
          if (at_pulse(cnt_reg, pd_reg)) begin
            link.select_n <= 1'b1;
            cnt_reg <= pd_reg ? CNT_W'(POWERDOWN_WAKE_CYC)
                              : CNT_W'(SLEEP_WAKE_CYC);
            state_reg <= HOST_WAIT;
          end
        end
        HOST_WAIT: begin
          if (cnt_reg == '0) begin
            state_reg <= HOST_IDLE;
            link.select_n <= 1'b1;
            link.data_host_oe <= 1'b0;
            busy_o <= 1'b0;
            ready_o <= 1'b1;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        default: state_reg <= HOST_IDLE;
      endcase
    end
  end

  function automatic logic at_limit(input logic [CNT_W-1:0] c);
    at_limit = (c >= CNT_W'(MAX_SELECT_LOW_CYC - 2));
  endfunction

  function automatic logic at_pulse(input logic [CNT_W-1:0] c,
                                    input logic pd);
    at_pulse = pd ? (c >= CNT_W'(POWERDOWN_WAKE_PULSE_MIN_CYC + 1))
                  : (c >= CNT_W'(SLEEP_WAKE_PULSE_MIN_CYC + 1));
  endfunction

  // Bus phase advance on each generated clock edge
  task automatic step_edge();
    if (state_reg == HOST_CMD) begin
      link.data_host_oe <= 1'b1;
      link.data_host <= (edge_reg == 4'h0) ? cmd_reg : 8'h00;
      if (edge_reg == 4'h5) begin
        edge_reg <= 4'h0;
        link.data_host_oe <= 1'b0;
        state_reg <= (!cmd_reg[CMD_READ_BIT] && cmd_reg[CMD_ZERO_LAT_BIT]) ?
                     HOST_DATA : HOST_LATENCY;
      end
    end else if (state_reg == HOST_LATENCY) begin
      if (edge_reg == 4'(2 * LATENCY_CLK - 1)) begin
        edge_reg <= 4'h0;
        state_reg <= HOST_DATA;
      end
    end else begin
      link.data_host_oe <= !cmd_reg[CMD_READ_BIT];
      link.data_host <= edge_reg[0] ? wdata_reg[7:0] : wdata_reg[15:8];
      if (edge_reg == 4'h3) begin
        // Hold select low until the device has sampled the last byte
        cnt_reg <= CNT_W'(HOST_CLK_HALF_CYC);
        state_reg <= HOST_WAIT;
      end
    end
  endtask

  // Clock pins, reset pin and strobe (never driven by host)
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      link.bus_clock <= 1'b0;
      link.bus_clock_complement <= 1'b1;
      link.reset_n <= 1'b0;
      link.strobe_host <= 1'b0;
      link.strobe_host_oe <= 1'b0;
    end else begin
      link.bus_clock <= clk_reg;
      link.bus_clock_complement <= ~clk_reg;
      link.reset_n <= ~pin_reset_i;
      link.strobe_host <= 1'b0;
      link.strobe_host_oe <= 1'b0;
    end
  end
endmodule // psram_host_end

// ### dv/psram_link_checker.sv
// Checker: timing and ownership rules on the link pins
`timescale 1ns/100ps
module psram_link_checker
  import psram_pwr_pkg::*;
(
  input wire logic core_clk_i, // Core clock
  input wire logic arst_n_i, // Async reset, active low
  input wire logic select_n, // Chip select, active low
  input wire logic bus_clock, // Bus clock from host
  input wire logic reset_n, // Hardware reset pin, active low
  input wire logic [7:0] data_dev, // Device data lines
  input wire logic data_host_oe, // Host drives data
  input wire logic data_dev_oe, // Device drives data
  input wire logic strobe_host_oe, // Host drives strobe
  input wire logic strobe_dev_oe // Device drives strobe
);
  logic [CNT_W-1:0] low_cnt_reg;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  // Count cycles with select held low
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      low_cnt_reg <= '0;
    end else if (select_n) begin
      low_cnt_reg <= '0;
    end else begin
      low_cnt_reg <= low_cnt_reg + 16'h1;
    end
  end
  a_standby_quiet: assert property (
    select_n && $past(select_n, 4) |-> !data_dev_oe && !strobe_dev_oe)
    else $error("device drives pins while deselected");
  a_ca_strobe_out: assert property (
    !select_n && $rose(bus_clock) && low_cnt_reg < 16'h10
    |-> ##[0:8] strobe_dev_oe) else $error("no strobe in command phase");
  a_data_one_owner: assert property (
    !(data_host_oe && data_dev_oe)) else $error("data lines contended");
  a_strobe_one_owner: assert property (
    !(strobe_host_oe && strobe_dev_oe)) else $error("strobe contended");
  a_pause_clock_low: assert property (
    (!select_n && bus_clock) [*5] |=> select_n || !bus_clock)
    else $error("bus clock paused high");
  a_select_low_max: assert property (
    low_cnt_reg < MAX_SELECT_LOW_CYC) else $error("select low too long");
  a_wake_pulse_min: assert property (
    $fell(select_n) |-> !select_n [*6]) else $error("select pulse short");
  a_stop_holds_read: assert property (
    (!select_n && data_dev_oe && $stable(bus_clock)) [*8]
    |=> $stable(data_dev)) else $error("read data moved in clock stop");
  a_reset_quiet: assert property (
    !reset_n && $past(!reset_n, 4) |-> !data_dev_oe && !strobe_dev_oe)
    else $error("device drives pins in reset");
  // Main scenarios seen
  c_transfer: cover property ($fell(select_n));
  c_clock_stop: cover property ((!select_n && $stable(bus_clock)) [*8]);
  c_pin_reset: cover property ($fell(reset_n));
endmodule // psram_link_checker

// ### dv/tb.sv
// Testbench: host end and device end joined over the link
`timescale 1ns/100ps
module tb;
  import psram_pwr_pkg::*;
  logic core_clk_i, arst_n_i, req_i, pause_i, wake_i, wake_pd_i;
  logic pin_reset_i, busy_o, ready_o, clock_stop_o, sleep_o;
  logic powerdown_o, refresh_en_o, data_valid_o;
  logic [7:0] cmd_i, wr_data_o, wr_mask_o, rd_data_o, rd_held;
  logic [15:0] wdata_i, cfg0_o, cfg1_o;
  int errors, check_count;
  psram_link_if lnk();
  psram_host_end psram_host_end_inst (.core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i), .link(lnk), .req_i(req_i), .cmd_i(cmd_i),
    .wdata_i(wdata_i), .pause_i(pause_i), .wake_i(wake_i),
    .wake_pd_i(wake_pd_i), .pin_reset_i(pin_reset_i), .busy_o(busy_o),
    .ready_o(ready_o));
  psram_dev_end psram_dev_end_inst (.core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i), .link(lnk), .wr_data_o(wr_data_o),
    .wr_strobe_o(), .wr_mask_o(wr_mask_o), .rd_data_o(rd_data_o),
    .clock_stop_o(clock_stop_o), .sleep_o(sleep_o),
    .powerdown_o(powerdown_o), .refresh_en_o(refresh_en_o),
    .data_valid_o(data_valid_o), .cfg0_o(cfg0_o), .cfg1_o(cfg1_o),
    .busy_refresh_i_unused_o());
  psram_link_checker psram_link_checker_inst (.core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i), .select_n(lnk.select_n),
    .bus_clock(lnk.bus_clock), .reset_n(lnk.reset_n),
    .data_dev(lnk.data_dev), .data_host_oe(lnk.data_host_oe),
    .data_dev_oe(lnk.data_dev_oe), .strobe_host_oe(lnk.strobe_host_oe),
    .strobe_dev_oe(lnk.strobe_dev_oe));
  task automatic print_verdict;
    if (errors == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  task automatic wait_ready(input int lim);
    int n;
    n = 0;
    @(posedge core_clk_i);
    while (ready_o !== 1'h1 && n < lim) begin
      @(posedge core_clk_i);
      n++;
    end
    check(ready_o, 1'h1);
    check(busy_o, 1'h0);
  endtask
  task automatic start(input logic [7:0] cmd, input logic [15:0] wd);
    @(posedge core_clk_i);
    req_i <= 1'h1;
    cmd_i <= cmd;
    wdata_i <= wd;
    @(posedge core_clk_i);
    req_i <= 1'h0;
  endtask
  task automatic txn(input logic [7:0] cmd, input logic [15:0] wd);
    start(cmd, wd);
    wait_ready(2000);
  endtask
  task automatic wake(input logic pd);
    @(posedge core_clk_i);
    wake_i <= 1'h1;
    wake_pd_i <= pd;
    @(posedge core_clk_i);
    wake_i <= 1'h0;
    wait_ready(20000);
  endtask
  // Core clock
  initial begin
    core_clk_i = 1'h0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  // Hang guard
  initial begin
    idle(60000);
    errors++;
    print_verdict;
  end
  // Main sequence
  initial begin
    errors = 0;
    check_count = 0;
    {arst_n_i, req_i, pause_i, wake_i, wake_pd_i, pin_reset_i} = 6'h00;
    cmd_i = 8'h00;
    wdata_i = 16'h0000;
    idle(16);
    arst_n_i <= 1'h1;
    idle(8);
    check(cfg0_o, CFG0_RESET);
    check(cfg1_o, CFG1_RESET);
    check(lnk.data_dev_oe, 1'h0);
    txn(8'h20, 16'ha55a);
    check(wr_data_o, 8'h5a);
    check(wr_mask_o, 8'h00);
    txn(8'h00, 16'h1234);
    start(8'h80, 16'h0000);
    idle(80);
    pause_i <= 1'h1;
    idle(15);
    rd_held = rd_data_o;
    idle(15);
    check(rd_data_o, rd_held);
    check(clock_stop_o, 1'h1);
    pause_i <= 1'h0;
    idle(10);
    check(clock_stop_o, 1'h0);
    wait_ready(2000);
    txn(8'h60, 16'hffa1);
    idle(5);
    check(sleep_o, 1'h1);
    check(cfg1_o, 16'hffa1);
    check(data_valid_o, 1'h1);
    wake(1'h0);
    check(sleep_o, 1'h0);
    check(cfg1_o, CFG1_RESET);
    txn(8'h60, 16'hff85);
    txn(8'h61, 16'h0f1f);
    idle(5);
    check(powerdown_o, 1'h1);
    check(refresh_en_o, 1'h0);
    check(data_valid_o, 1'h0);
    wake(1'h1);
    check(powerdown_o, 1'h0);
    check(cfg0_o, CFG0_RESET);
    check(cfg1_o, CFG1_RESET);
    txn(8'h20, 16'h0102);
    check(wr_data_o, 8'h02);
    txn(8'h60, 16'hffa1);
    idle(5);
    pin_reset_i <= 1'h1;
    idle(20);
    pin_reset_i <= 1'h0;
    idle(10);
    check(sleep_o, 1'h0);
    check(data_valid_o, 1'h0);
    check(cfg1_o, CFG1_RESET);
    print_verdict;
  end
endmodule // tb
